// ==== rtl/ext_bus_defs.svh ====
// Constants for the external bus, port pin and reset logic.
// Assumes one 125 MHz clock; all counts are in cycles of that clock.
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define CLK_PERIOD_NS 8
`define RESET_FILTER_CLKS 3'd4
`define RESET_HOLD_CLKS 5'd18
`define RESET_START_ADDR 16'h000c
`define EXT_WAIT_CLKS 2'd2
`define NORM_WAIT_CLKS 2'd0
`define P0_MODE_RESET 2'b11
`define EXT_TIMING_RESET 1'b1
`define NIB_LO 3:0
`define NIB_HI 7:4
`endif

// ==== rtl/ext_bus_pkg.sv ====
// Types shared by the external bus and port pin logic.
// Assumes the constants header is included by the design file.
package ext_bus_pkg;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_HOLD = 3'b010,
		BUS_DATA = 3'b011,
		BUS_DONE = 3'b100
	} bus_state_type;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WAIT = 2'b01,
		HS_DONE = 2'b10
	} hs_state_type;
endpackage : ext_bus_pkg

// ==== rtl/ext_bus_ports.sv ====
// External memory bus, reset sequencer, emulation outputs and port 0/1/2 pin logic.
// Assumes a core that issues one bus request at a time and synchronous pin inputs.
// Function
// - sixteen address lines, two 64K spaces
// - data strobe once per transfer
// - write data valid at strobe fall
// - address strobe pulses at cycle start
// - tri-state strobes, direction and address ports
// - direction line low write, high read
// - reset shorter than four clocks ignored
// - latch reset on fifth clock, hold 18
// - in reset data strobe low, address strobe toggles
// - fetch starts at 000C after reset
// - system clock driven out
// - interrupt flag high during interrupt cycle
// - instruction end low on last cycle
// - port 0 nibbles: I/O or address
// - port 0 handshake on port 3 bits 2,5
// - reset: port 0 address, extended timing
// - low nibble address, high nibble I/O
// - port 1 is multiplexed address/data bus
// - upper address from port 0
// - port 2 per-bit direction, open-drain option
// - port 2 handshake on port 3 bits 1,6
// - data space select low for data-space accesses, reads and writes
`timescale 1ns/100ps
`include "ext_bus_defs.svh"

module port_handshake
	import ext_bus_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic is_output,
	input wire logic load,
	input wire logic [WIDTH-1:0] pin_data,
	input wire logic line_in,
	output logic line_out,
	output logic busy,
	output logic [WIDTH-1:0] captured,
	output logic captured_pulse
);
	hs_state_type state, next_state;
	logic [WIDTH-1:0] next_captured;
	logic next_captured_pulse;
	always_comb begin
		next_state = state;
		next_captured = captured;
		next_captured_pulse = 1'b0;
		if (!enable) begin
			next_state = HS_IDLE;
		end else begin
			case (state)
				HS_IDLE: begin
					if (is_output && load) begin
						next_state = HS_WAIT;
					end else if (!is_output && !line_in) begin
						next_captured = pin_data;
						next_captured_pulse = 1'b1;
						next_state = HS_DONE;
					end
				end
				HS_WAIT: begin
					if (line_in) begin
						next_state = HS_DONE;
					end
				end
				HS_DONE: begin
					if (is_output ? !line_in : line_in) begin
						next_state = HS_IDLE;
					end
				end
				default: next_state = HS_IDLE;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= HS_IDLE;
			captured <= '0;
			captured_pulse <= 1'b0;
		end else begin
			state <= next_state;
			captured <= next_captured;
			captured_pulse <= next_captured_pulse;
		end
	end
	// Sender drives valid low only while waiting for ready; receiver raises ready after capture.
	always_comb begin
		if (is_output) begin
			line_out = !(state == HS_WAIT);
		end else begin
			line_out = (state == HS_DONE);
		end
		busy = (state != HS_IDLE);
	end
endmodule : port_handshake

module ext_bus_ports
	import ext_bus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ext_reset_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_data_space,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic req_ready,
	output logic req_done,
	output logic [7:0] rd_data,
	output logic core_reset,
	output logic fetch_start,
	output logic [15:0] fetch_addr,
	input wire logic in_interrupt_cycle,
	input wire logic instr_last_cycle,
	output logic system_clock_out,
	output logic interrupt_cycle_flag,
	output logic instruction_end_n,
	input wire logic bus_float,
	input wire logic mode_we,
	input wire logic [1:0] p0_addr_mode_wdata,
	input wire logic ext_timing_wdata,
	output logic [1:0] p0_addr_mode,
	output logic ext_timing,
	output logic address_strobe_n,
	output logic address_strobe_oe,
	output logic data_strobe_n,
	output logic data_strobe_oe,
	output logic write_low_read_high,
	output logic write_low_read_high_oe,
	input wire logic [7:0] muxed_addr_data_bus_in,
	output logic [7:0] muxed_addr_data_bus_out,
	output logic [7:0] muxed_addr_data_bus_oe,
	input wire logic [7:0] port0_in,
	output logic [7:0] port0_out,
	output logic [7:0] port0_oe,
	input wire logic [1:0] port0_nibble_dir,
	input wire logic [7:0] port0_io_data,
	input wire logic port0_handshake_en,
	input wire logic port0_load,
	output logic port0_busy,
	output logic [7:0] port0_captured,
	output logic port0_captured_pulse,
	input wire logic [7:0] port2_in,
	output logic [7:0] port2_out,
	output logic [7:0] port2_oe,
	input wire logic [7:0] port2_dir,
	input wire logic port2_open_drain,
	input wire logic [7:0] port2_io_data,
	input wire logic port2_handshake_en,
	input wire logic port2_load,
	output logic port2_busy,
	output logic [7:0] port2_captured,
	output logic port2_captured_pulse,
	input wire logic dm_enable,
	input wire logic [2:0] port3_gp_out,
	input wire logic port_three_bit_one,
	input wire logic port_three_bit_two,
	output logic port_three_bit_four,
	output logic port_three_bit_five,
	output logic port_three_bit_six
);
	// Reset filter and sequencer.
	logic [2:0] low_cnt, next_low_cnt;
	logic [4:0] hold_cnt, next_hold_cnt;
	logic rst_int, next_rst_int;
	logic next_fetch_start;
	logic as_toggle, next_as_toggle;
	always_comb begin
		next_low_cnt = low_cnt;
		next_hold_cnt = hold_cnt;
		next_rst_int = rst_int;
		next_fetch_start = 1'b0;
		next_as_toggle = rst_int ? !as_toggle : 1'b1;
		if (ext_reset_n) begin
			next_low_cnt = 3'd0;
		end else if (low_cnt != `RESET_FILTER_CLKS) begin
			next_low_cnt = low_cnt + 3'd1;
		end
		if (!rst_int && low_cnt == `RESET_FILTER_CLKS) begin
			next_rst_int = 1'b1;
			next_hold_cnt = 5'd0;
		end else if (rst_int) begin
			// The set edge is the first held clock, so the count stops one short.
			if (hold_cnt != `RESET_HOLD_CLKS - 5'd1) begin
				next_hold_cnt = hold_cnt + 5'd1;
			end else if (ext_reset_n) begin
				next_rst_int = 1'b0;
				next_fetch_start = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt <= 3'd0;
			hold_cnt <= 5'd0;
			rst_int <= 1'b1;
			fetch_start <= 1'b0;
			as_toggle <= 1'b1;
		end else begin
			low_cnt <= next_low_cnt;
			hold_cnt <= next_hold_cnt;
			rst_int <= next_rst_int;
			fetch_start <= next_fetch_start;
			as_toggle <= next_as_toggle;
		end
	end
	assign core_reset = rst_int;
	assign fetch_addr = `RESET_START_ADDR;

	// Mode bits: a write strobe updates them, internal reset restores them.
	logic [1:0] next_p0_addr_mode;
	logic next_ext_timing;
	always_comb begin
		next_p0_addr_mode = p0_addr_mode;
		next_ext_timing = ext_timing;
		if (rst_int) begin
			next_p0_addr_mode = `P0_MODE_RESET;
			next_ext_timing = `EXT_TIMING_RESET;
		end else if (mode_we) begin
			next_p0_addr_mode = p0_addr_mode_wdata;
			next_ext_timing = ext_timing_wdata;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			p0_addr_mode <= `P0_MODE_RESET;
			ext_timing <= `EXT_TIMING_RESET;
		end else begin
			p0_addr_mode <= next_p0_addr_mode;
			ext_timing <= next_ext_timing;
		end
	end

	// Bus cycle sequencer.
	bus_state_type state, next_state;
	logic [15:0] addr_q, next_addr_q;
	logic [7:0] wdata_q, next_wdata_q;
	logic write_q, next_write_q;
	logic dspace_q, next_dspace_q;
	logic [1:0] wait_cnt, next_wait_cnt;
	logic [7:0] next_rd_data;
	logic next_req_done;
	always_comb begin
		next_state = state;
		next_addr_q = addr_q;
		next_wdata_q = wdata_q;
		next_write_q = write_q;
		next_dspace_q = dspace_q;
		next_wait_cnt = wait_cnt;
		next_rd_data = rd_data;
		next_req_done = 1'b0;
		case (state)
			BUS_IDLE: begin
				if (req_valid && !rst_int) begin
					next_addr_q = req_addr;
					next_wdata_q = req_wdata;
					next_write_q = req_write;
					next_dspace_q = req_data_space;
					next_state = BUS_ADDR;
				end
			end
			BUS_ADDR: next_state = BUS_HOLD;
			BUS_HOLD: begin
				next_wait_cnt = ext_timing ? `EXT_WAIT_CLKS : `NORM_WAIT_CLKS;
				next_state = BUS_DATA;
			end
			BUS_DATA: begin
				if (wait_cnt != 2'd0) begin
					next_wait_cnt = wait_cnt - 2'd1;
				end else begin
					// Sampled in the last strobe-low cycle, before the strobe rises.
					if (!write_q) begin
						next_rd_data = muxed_addr_data_bus_in;
					end
					next_state = BUS_DONE;
				end
			end
			BUS_DONE: begin
				next_req_done = 1'b1;
				next_state = BUS_IDLE;
			end
			default: next_state = BUS_IDLE;
		endcase
		if (rst_int) begin
			next_state = BUS_IDLE;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= BUS_IDLE;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			write_q <= 1'b0;
			dspace_q <= 1'b0;
			wait_cnt <= 2'd0;
			rd_data <= 8'h00;
			req_done <= 1'b0;
		end else begin
			state <= next_state;
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			write_q <= next_write_q;
			dspace_q <= next_dspace_q;
			wait_cnt <= next_wait_cnt;
			rd_data <= next_rd_data;
			req_done <= next_req_done;
		end
	end
	assign req_ready = (state == BUS_IDLE) && !rst_int;

	// Strobe and direction pins.
	logic active;
	always_comb begin
		active = (state != BUS_IDLE);
		if (rst_int) begin
			address_strobe_n = as_toggle;
			data_strobe_n = 1'b0;
			write_low_read_high = 1'b1;
		end else begin
			address_strobe_n = !(state == BUS_ADDR);
			data_strobe_n = !(state == BUS_DATA);
			write_low_read_high = !(active && write_q);
		end
		address_strobe_oe = !bus_float;
		data_strobe_oe = !bus_float;
		write_low_read_high_oe = !bus_float;
	end

	// Port 1: address during the strobe, write data from the hold cycle on.
	always_comb begin
		muxed_addr_data_bus_out = 8'h00;
		muxed_addr_data_bus_oe = 8'h00;
		if (!rst_int && !bus_float) begin
			if (state == BUS_ADDR) begin
				muxed_addr_data_bus_out = addr_q[7:0];
				muxed_addr_data_bus_oe = 8'hff;
			end else if (write_q && active) begin
				muxed_addr_data_bus_out = wdata_q;
				muxed_addr_data_bus_oe = 8'hff;
			end
		end
	end

	// Port 0: each nibble carries address or general I/O.
	logic p0_hs_en, p0_hs_out, p0_line_out;
	always_comb begin
		port0_out[`NIB_LO] = p0_addr_mode[0] ? addr_q[11:8] : port0_io_data[`NIB_LO];
		port0_out[`NIB_HI] = p0_addr_mode[1] ? addr_q[15:12] : port0_io_data[`NIB_HI];
		port0_oe[`NIB_LO] = p0_addr_mode[0] ? {4{!bus_float}} : {4{port0_nibble_dir[0]}};
		port0_oe[`NIB_HI] = p0_addr_mode[1] ? {4{!bus_float}} : {4{port0_nibble_dir[1]}};
		// Handshake needs both nibbles as I/O and agreeing in direction.
		p0_hs_en = port0_handshake_en && (p0_addr_mode == 2'b00)
			&& (port0_nibble_dir[0] == port0_nibble_dir[1]);
		p0_hs_out = port0_nibble_dir[1];
	end
	port_handshake #(.WIDTH(8)) u_p0_hs (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(p0_hs_en),
		.is_output(p0_hs_out),
		.load(port0_load),
		.pin_data(port0_in),
		.line_in(port_three_bit_two),
		.line_out(p0_line_out),
		.busy(port0_busy),
		.captured(port0_captured),
		.captured_pulse(port0_captured_pulse)
	);

	// Port 2: per-bit direction, open drain only drives low.
	logic p2_line_out;
	always_comb begin
		port2_out = port2_io_data;
		port2_oe = port2_open_drain ? (port2_dir & ~port2_io_data) : port2_dir;
	end
	port_handshake #(.WIDTH(8)) u_p2_hs (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(port2_handshake_en),
		.is_output(port2_dir[7]),
		.load(port2_load),
		.pin_data(port2_in),
		.line_in(port_three_bit_one),
		.line_out(p2_line_out),
		.busy(port2_busy),
		.captured(port2_captured),
		.captured_pulse(port2_captured_pulse)
	);

	// Port 3 outputs and emulation pins.
	logic sclk_q, next_sclk_q, interrupt_cycle_flag_q, next_interrupt_cycle_flag_q, iend_q, next_iend_q;
	always_comb begin
		port_three_bit_four = dm_enable ? !(active && dspace_q) : port3_gp_out[0];
		port_three_bit_five = p0_hs_en ? p0_line_out : port3_gp_out[1];
		port_three_bit_six = port2_handshake_en ? p2_line_out : port3_gp_out[2];
		next_sclk_q = !sclk_q;
		next_interrupt_cycle_flag_q = in_interrupt_cycle;
		next_iend_q = !instr_last_cycle;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			interrupt_cycle_flag_q <= 1'b0;
			iend_q <= 1'b1;
		end else begin
			sclk_q <= next_sclk_q;
			interrupt_cycle_flag_q <= next_interrupt_cycle_flag_q;
			iend_q <= next_iend_q;
		end
	end
	// The emulation pins lag the core by one cycle to keep them glitch free.
	assign system_clock_out = sclk_q;
	assign interrupt_cycle_flag = interrupt_cycle_flag_q;
	assign instruction_end_n = iend_q;
endmodule : ext_bus_ports

// ==== bench/ext_mem_model.sv ====
// Behavioural external memory on the multiplexed bus.
// Assumes the bench resolves the bus and port 0 pin levels before they arrive here.
`timescale 1ns/100ps
module ext_mem_model (
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic write_low_read_high,
	input wire logic [7:0] bus_level,
	input wire logic [7:0] upper_addr,
	output logic [7:0] mem_drive
);
	logic [7:0] mem [bit [15:0]];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	// Sampling a little after each strobe falls keeps clear of the edge that moves the bus.
	always @(negedge address_strobe_n) begin
		#2;
		addr = {upper_addr, bus_level};
	end
	always @(negedge data_strobe_n) begin
		#2;
		if (write_low_read_high === 1'b0) mem[addr] = bus_level;
	end
	always @(negedge data_strobe_n) last = mem.exists(addr) ? mem[addr] : ~last;
	// A released bus shows the inverse of the last byte, so stale data never passes.
	assign mem_drive = (data_strobe_n === 1'b0 && write_low_read_high === 1'b1) ? last : ~last;
endmodule : ext_mem_model

// ==== bench/ext_bus_ports_properties.sv ====
// Concurrent checks on the external bus and reset block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module ext_bus_ports_properties (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_wdata,
	input wire logic req_ready,
	input wire logic req_done,
	input wire logic core_reset,
	input wire logic fetch_start,
	input wire logic [15:0] fetch_addr,
	input wire logic in_interrupt_cycle,
	input wire logic instr_last_cycle,
	input wire logic system_clock_out,
	input wire logic interrupt_cycle_flag,
	input wire logic instruction_end_n,
	input wire logic bus_float,
	input wire logic ext_timing,
	input wire logic address_strobe_n,
	input wire logic address_strobe_oe,
	input wire logic data_strobe_n,
	input wire logic data_strobe_oe,
	input wire logic write_low_read_high,
	input wire logic write_low_read_high_oe,
	input wire logic [7:0] muxed_addr_data_bus_out,
	input wire logic [7:0] muxed_addr_data_bus_oe,
	input wire logic port0_captured_pulse
);
	wire logic take = req_valid && req_ready;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_as; take |=> !address_strobe_n ##1 address_strobe_n; endproperty
	a_as: assert property (p_as) else $error("address strobe pulse wrong");
	property p_ds; take |=> data_strobe_n[*2] ##1 !data_strobe_n; endproperty
	a_ds: assert property (p_ds) else $error("data strobe timing wrong");
	property p_wd; take && req_write |-> ##3 (!data_strobe_n &&
		muxed_addr_data_bus_out == $past(req_wdata, 3) && muxed_addr_data_bus_oe == 8'hff); endproperty
	a_wd: assert property (p_wd) else $error("write data not valid at strobe");
	property p_rw; take && req_write |=> !write_low_read_high[*3]; endproperty
	a_rw: assert property (p_rw) else $error("direction line high in write");
	property p_fast; take && !ext_timing |=> !req_done[*4] ##1 req_done; endproperty
	a_fast: assert property (p_fast) else $error("normal transfer length wrong");
	property p_slow; take && ext_timing |=> !req_done[*6] ##1 req_done; endproperty
	a_slow: assert property (p_slow) else $error("extended transfer length wrong");
	property p_idle; req_done |=> address_strobe_n && data_strobe_n && write_low_read_high; endproperty
	a_idle: assert property (p_idle) else $error("strobe active between cycles");
	property p_float; bus_float |-> !address_strobe_oe && !data_strobe_oe &&
		!write_low_read_high_oe && muxed_addr_data_bus_oe == 8'h00; endproperty
	a_float: assert property (p_float) else $error("bus driven while floated");
	property p_rds; core_reset |-> !data_strobe_n; endproperty
	a_rds: assert property (p_rds) else $error("data strobe high in reset");
	property p_ras; core_reset && $past(core_reset) && $past(rst_b, 2) |->
		address_strobe_n != $past(address_strobe_n); endproperty
	a_ras: assert property (p_ras) else $error("address strobe not toggling in reset");
	property p_fetch; fetch_start |-> fetch_addr == 16'h000c && !core_reset; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch start address wrong");
	property p_sclk; $past(rst_b) |-> system_clock_out != $past(system_clock_out); endproperty
	a_sclk: assert property (p_sclk) else $error("system clock output stuck");
	property p_interrupt_cycle_flag; $rose(in_interrupt_cycle) |=> interrupt_cycle_flag; endproperty
	a_interrupt_cycle_flag: assert property (p_interrupt_cycle_flag) else $error("interrupt flag missing");
	property p_end; instr_last_cycle |=> !instruction_end_n; endproperty
	a_end: assert property (p_end) else $error("instruction end missing");
	c_write: cover property (take && req_write);
	c_fetch: cover property (fetch_start);
	c_cap: cover property (port0_captured_pulse);
endmodule : ext_bus_ports_properties
bind ext_bus_ports ext_bus_ports_properties props (.*);

// ==== bench/external_bus_ports_and_reset_tb.sv ====
// Self-checking bench for the external bus, reset and port pin block.
// Assumes the design, the memory model and the bound checker are compiled first.
`timescale 1ns/100ps
`include "ext_bus_defs.svh"
module external_bus_ports_and_reset_tb;
	logic ref_clk = 0, rst_b = 0, ext_reset_n = 1, req_valid = 0, req_write = 0;
	logic req_data_space = 0, in_interrupt_cycle = 0, instr_last_cycle = 0, bus_float = 0;
	logic mode_we = 0, ext_timing_wdata = 1, port0_handshake_en = 0, port0_load = 0;
	logic port2_open_drain = 0, port2_handshake_en = 0, port2_load = 0, dm_enable = 1;
	logic port_three_bit_one = 0, port_three_bit_two = 1;
	logic [1:0] p0_addr_mode_wdata = 2'b11, port0_nibble_dir = 2'b00, p0_addr_mode;
	logic [2:0] port3_gp_out = 3'h0;
	logic [7:0] req_wdata = 8'h00, port0_io_data = 8'h00, port2_dir = 8'h00;
	logic [7:0] port2_io_data = 8'h00, p0_ext = 8'h00, mem_drive, rd_data;
	logic [15:0] req_addr = 16'h0000, fetch_addr;
	logic req_ready, req_done, core_reset, fetch_start, system_clock_out, interrupt_cycle_flag;
	logic instruction_end_n, ext_timing, address_strobe_n, address_strobe_oe, data_strobe_n;
	logic data_strobe_oe, write_low_read_high, write_low_read_high_oe, port0_busy, port2_busy;
	logic port0_captured_pulse, port2_captured_pulse, port_three_bit_four;
	logic port_three_bit_five, port_three_bit_six;
	logic [7:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out, muxed_addr_data_bus_oe;
	logic [7:0] port0_in, port0_out, port0_oe, port0_captured;
	logic [7:0] port2_in, port2_out, port2_oe, port2_captured;
	int fails = 0, checked = 0;
	always #4 ref_clk = ~ref_clk;
	assign muxed_addr_data_bus_in = (muxed_addr_data_bus_oe & muxed_addr_data_bus_out) |
		(~muxed_addr_data_bus_oe & mem_drive);
	assign port0_in = (port0_oe & port0_out) | (~port0_oe & p0_ext);
	// Port 2 pins carry a pull-up, so released bits, open-drain ones not driving low included, read high.
	assign port2_in = (port2_oe & port2_out) | ~port2_oe;
	ext_bus_ports dut (.*);
	ext_mem_model mem (.address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
		.write_low_read_high(write_low_read_high), .bus_level(muxed_addr_data_bus_in),
		.upper_addr(port0_in), .mem_drive(mem_drive));
	task summarize;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v = 1'b1);
		int i;
		for (i = 0; i < 60 && s !== v; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (s !== v) begin
			fails++;
			summarize();
		end
	endtask : wt
	task rel;
		int n;
		n = 0;
		while (core_reset === 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("reset_len", n, `RESET_HOLD_CLKS);
		chk("fetch_start", fetch_start, 1'b1);
		chk("fetch_addr", fetch_addr, `RESET_START_ADDR);
	endtask : rel
	task mode(input logic [1:0] m, input logic t);
		@(posedge ref_clk);
		mode_we <= 1'b1;
		p0_addr_mode_wdata <= m;
		ext_timing_wdata <= t;
		@(posedge ref_clk);
		mode_we <= 1'b0;
		#1 chk("p0_mode", p0_addr_mode, m);
		chk("ext_timing", ext_timing, t);
	endtask : mode
	task bus(input logic w, input logic d, input logic [15:0] a, input logic [7:0] wd);
		wt(req_ready);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_data_space <= d;
		req_addr <= a;
		req_wdata <= wd;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		#1 chk("upper_addr", port0_in[3:0], a[11:8]);
		chk("dm_select", port_three_bit_four, !d);
		wt(req_done);
		if (!w) chk("rd_data", rd_data, wd);
	endtask : bus
	task t_reset;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1 rel();
		chk("p0_mode_rst", p0_addr_mode, 2'b11);
		chk("ext_rst", ext_timing, 1'b1);
		@(posedge ref_clk);
		ext_reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ext_reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk("short_reset", core_reset, 1'b0);
		@(posedge ref_clk);
		ext_reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		ext_reset_n <= 1'b1;
		#1 chk("reset_early", core_reset, 1'b0);
		@(posedge ref_clk);
		#1 chk("reset_set", core_reset, 1'b1);
		rel();
	endtask : t_reset
	task t_misc;
		@(posedge ref_clk);
		bus_float <= 1'b1;
		in_interrupt_cycle <= 1'b1;
		instr_last_cycle <= 1'b1;
		@(posedge ref_clk);
		in_interrupt_cycle <= 1'b0;
		instr_last_cycle <= 1'b0;
		#1 chk("float_p0_oe", port0_oe, 8'h00);
		chk("interrupt_cycle_flag", interrupt_cycle_flag, 1'b1);
		chk("end_n", instruction_end_n, 1'b0);
		@(posedge ref_clk);
		bus_float <= 1'b0;
	endtask : t_misc
	task t_ports;
		bus(1'b1, 1'b1, 16'ha35a, 8'h3c);
		bus(1'b0, 1'b1, 16'ha35a, 8'h3c);
		port0_nibble_dir <= 2'b10;
		port0_io_data <= 8'h96;
		mode(2'b01, 1'b0);
		chk("p0_io_hi", port0_out[7:4], 4'h9);
		bus(1'b1, 1'b0, 16'h0fff, 8'hc5);
		bus(1'b0, 1'b0, 16'h0fff, 8'hc5);
		port0_nibble_dir <= 2'b00;
		port0_handshake_en <= 1'b1;
		p0_ext <= 8'h6b;
		mode(2'b00, 1'b0);
		port_three_bit_two <= 1'b0;
		wt(port0_captured_pulse);
		chk("p0_capture", port0_captured, 8'h6b);
		chk("p0_ready", port_three_bit_five, 1'b1);
		chk("p0_busy", port0_busy, 1'b1);
		@(posedge ref_clk);
		port_three_bit_two <= 1'b1;
		port2_dir <= 8'hff;
		port2_open_drain <= 1'b1;
		port2_io_data <= 8'h0f;
		@(posedge ref_clk);
		#1 chk("p2_od_oe", port2_oe, 8'hf0);
		@(posedge ref_clk);
		port2_open_drain <= 1'b0;
		port2_io_data <= 8'hc3;
		port2_handshake_en <= 1'b1;
		port2_load <= 1'b1;
		@(posedge ref_clk);
		port2_load <= 1'b0;
		#1 chk("p2_dav", port_three_bit_six, 1'b0);
		chk("p2_data", port2_out, 8'hc3);
		@(posedge ref_clk);
		port_three_bit_one <= 1'b1;
		wt(port_three_bit_six);
		@(posedge ref_clk);
		port_three_bit_one <= 1'b0;
		wt(port2_busy, 1'b0);
		@(posedge ref_clk);
		port2_dir <= 8'h00;
		wt(port2_captured_pulse);
		chk("p2_capture", port2_captured, 8'hff);
		chk("p2_ready", port_three_bit_six, 1'b1);
	endtask : t_ports
	initial begin
		t_reset();
		t_misc();
		t_ports();
		summarize();
	end
endmodule : external_bus_ports_and_reset_tb
